//--- test/qvf_controller_sva.sv
`timescale 1ns/10ps
`default_nettype none
module qvf_controller_sva #(
  parameter int unsigned AUX_CYC = 50,
  parameter int unsigned LL_CYC  = 40
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic valley_below_55mv_i,
  input wire logic valley_above_1v_i,
  input wire logic line_below_low_line_i,
  input wire logic line_above_high_line_i,
  input wire logic cs_above_peak_limit_i,
  input wire logic cs_above_setpoint_i,
  input wire logic gate_o,
  input wire logic comp_ground_o,
  input wire logic high_line_o,
  input wire logic aux_short_fault_o,
  input wire logic winding_diode_short_fault_o,
  input wire logic programmable_overvoltage_fault_o,
  input wire logic latched_o
);
  int unsigned quiet_q;
  int unsigned below_q;
  // ---------------------------------------------------------------
  // Raw run lengths; the design lags them by its synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
    quiet_q <= (rst_i || valley_above_1v_i) ? 0 : quiet_q + 1;
  always_ff @(posedge clock_i or posedge rst_i)
    below_q <= (rst_i || !line_below_low_line_i) ? 0 : below_q + 1;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_HIGH_LINE:
    assert property (line_above_high_line_i [*4] |-> high_line_o)
    else $error("high line late");
  AST_LOW_LINE:
    assert property ($fell(high_line_o) |-> below_q >= LL_CYC)
    else $error("low line early");
  AST_AUX_TIMER:
    assert property ($rose(aux_short_fault_o) |-> quiet_q >= AUX_CYC)
    else $error("aux fault early");
  AST_SETPOINT_END:
    assert property (gate_o && $rose(cs_above_setpoint_i) |-> ##[1:3] !gate_o)
    else $error("gate outlived setpoint");
  AST_PEAK_END:
    assert property (gate_o && $rose(cs_above_peak_limit_i) |-> ##[1:18] !gate_o)
    else $error("gate outlived peak limit");
  AST_GATE_REFUSED:
    assert property (latched_o || comp_ground_o |-> !gate_o)
    else $error("gate while halted");
  AST_FAULT_HALT:
    assert property ((aux_short_fault_o || winding_diode_short_fault_o
      || programmable_overvoltage_fault_o) [*2] |-> !gate_o)
    else $error("gate after fault");
  AST_VALLEY_START:
    assert property ($rose(gate_o) |-> $past(valley_below_55mv_i, 3))
    else $error("gate without valley");
  cover property ($rose(winding_diode_short_fault_o));
  cover property ($rose(latched_o));
  cover property ($fell(high_line_o));
endmodule : qvf_controller_sva
bind qvf_controller qvf_controller_sva #(.AUX_CYC(AUX_CYC), .LL_CYC(LL_CYC)) u_sva (.*);
`default_nettype wire

//--- test/qvf_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
module qvf_stage_model
(
  input  wire logic clock_i,
  input  wire logic gate_i,
  input  wire logic short_i,
  input  wire logic dead_i,
  output logic      below_o,
  output logic      above_o,
  output logic      peak_o,
  output logic      over_o,
  output logic      set_o
);
  int   t = 0;
  logic g = 1'b0;
  // ---------------------------------------------------------------
  // Ramp while on, ringing while off; a dead winding sits low
  // ---------------------------------------------------------------
  initial {below_o, above_o, peak_o, over_o, set_o} = '0;
  always @(negedge clock_i)
  begin
    t = (gate_i === g) ? t + 1 : 0;
    g = gate_i;
    peak_o  <= g && short_i && t >= 16;
    over_o  <= g && short_i && t >= 16;
    set_o   <= g && t >= 24;
    above_o <= !g && !dead_i && t < 8;
    below_o <= dead_i || (!g && t >= 12 && t % 8 >= 4);
  end
endmodule : qvf_stage_model
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int AUX = 1000;
  localparam int LL  = 400;
  localparam int REC = 800;
  logic       clock_i = 1'b0;
  logic       rst_i   = 1'b1;
  logic       variant_latching_i, variant_low_ref_i, line_below_low_line_i;
  logic       line_above_high_line_i, supply_above_turn_on_i, supply_below_turn_off_i;
  logic       supply_below_reset_i, supply_overvoltage_i, shutdown_above_2v5_i;
  logic       thermal_foldback_i, amp_sinking_i, short_mode, dead_mode;
  logic [3:0] foldback_valleys_i = 4'h4;
  logic       valley_below_55mv_i, valley_above_1v_i, cs_above_peak_limit_i;
  logic       cs_above_150pct_i, cs_above_setpoint_i, gate_o, comp_ground_o;
  logic       comp_boost_o, ref_low_o, ref_foldback_o, high_line_o, latched_o;
  logic       aux_short_fault_o, winding_diode_short_fault_o;
  logic       programmable_overvoltage_fault_o;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         n;
  initial forever #10 clock_i = ~clock_i;
  qvf_controller #(.AUX_CYC(AUX), .LL_CYC(LL), .RECOV_CYC(REC)) DUT (.*);
  qvf_stage_model u_stage (
    .clock_i (clock_i),
    .gate_i  (gate_o),
    .short_i (short_mode),
    .dead_i  (dead_mode),
    .below_o (valley_below_55mv_i),
    .above_o (valley_above_1v_i),
    .peak_o  (cs_above_peak_limit_i),
    .over_o  (cs_above_150pct_i),
    .set_o   (cs_above_setpoint_i)
  );
  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  // Stage timing is seen through a half-cycle offset, hence the slack
  function automatic logic [31:0] near(int v, int e);
    return (v >= e - 2 && v <= e + 2) ? e : v;
  endfunction : near
  function automatic logic sig(int k);
    logic [3:0] s;
    s = {latched_o, aux_short_fault_o, winding_diode_short_fault_o, gate_o};
    return s[k];
  endfunction : sig
  task automatic cyc(int c);
    repeat (c) @(negedge clock_i);
  endtask : cyc
  task automatic wt(int k, logic v, output int c);
    c = 0;
    while (sig(k) !== v && c < 5000)
    begin
      @(negedge clock_i);
      c++;
    end
    if (c >= 5000)
      chk("wait", v, sig(k));
  endtask : wt
  task automatic off(output int c);
    wt(0, 1'b0, c);
    wt(0, 1'b1, c);
    wt(0, 1'b0, c);
    wt(0, 1'b1, c);
  endtask : off
  task automatic restart(logic lat, logic lref);
    rst_i = 1'b1;
    {variant_latching_i, variant_low_ref_i} = {lat, lref};
    {line_below_low_line_i, line_above_high_line_i, supply_above_turn_on_i,
     supply_below_turn_off_i, supply_below_reset_i, supply_overvoltage_i,
     shutdown_above_2v5_i, thermal_foldback_i, amp_sinking_i, short_mode, dead_mode} = '0;
    cyc(16);
    chk("reset_ground", 1, comp_ground_o);
    chk("reset_gate", 0, gate_o);
    rst_i = 1'b0;
    {supply_above_turn_on_i, line_below_low_line_i} = 2'b11;
  endtask : restart
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_low_line();
    cyc(4);
    chk("boost", 1, comp_boost_o);
    chk("ref_low", 0, ref_low_o);
    chk("ref_nofold", 0, ref_foldback_o);
    wt(0, 1'b1, n);
    wt(0, 1'b0, n);
    chk("on_time", 27, near(n, 27));
    off(n);
    chk("off_valley1", 15, near(n, 15));
    amp_sinking_i = 1'b1;
    cyc(4);
    chk("boost_off", 0, comp_boost_o);
    {supply_below_turn_off_i, supply_above_turn_on_i} = 2'b10;
    cyc(4);
    chk("dip_gate", 0, gate_o);
    chk("dip_ground", 0, comp_ground_o);
    {supply_below_turn_off_i, supply_above_turn_on_i} = 2'b01;
    wt(0, 1'b1, n);
    chk("retry_gate", 1, gate_o);
  endtask : t_low_line
  task automatic t_high_fold();
    {line_above_high_line_i, line_below_low_line_i} = 2'b10;
    cyc(4);
    chk("high_line", 1, high_line_o);
    off(n);
    chk("off_valley2", 23, near(n, 23));
    {line_above_high_line_i, line_below_low_line_i} = 2'b01;
    cyc(LL - 10);
    chk("low_line_early", 1, high_line_o);
    cyc(20);
    chk("low_line", 0, high_line_o);
    thermal_foldback_i = 1'b1;
    off(n);
    chk("ref_fold", 1, ref_foldback_o);
    chk("off_valley4", 39, near(n, 39));
  endtask : t_high_fold
  task automatic t_short();
    restart(1'b0, 1'b1);
    short_mode = 1'b1;
    wt(0, 1'b1, n);
    wt(0, 1'b0, n);
    chk("on_limit", 19, near(n, 19));
    chk("ref_low", 1, ref_low_o);
    off(n);
    wt(0, 1'b0, n);
    chk("wod_early", 0, winding_diode_short_fault_o);
    wt(1, 1'b1, n);
    chk("wod_fourth", 1, n < 60);
    chk("wod_latched", 0, latched_o);
    chk("wod_ground", 1, comp_ground_o);
    short_mode = 1'b0;
    wt(0, 1'b1, n);
    chk("recover_wait", 1, n >= REC);
  endtask : t_short
  task automatic t_aux();
    restart(1'b1, 1'b0);
    dead_mode = 1'b1;
    wt(2, 1'b1, n);
    chk("aux_time", 1, n >= AUX);
    cyc(2);
    chk("aux_latched", 1, latched_o);
    dead_mode = 1'b0;
    cyc(REC + 50);
    chk("latch_holds", 1, latched_o);
    {supply_below_reset_i, supply_above_turn_on_i} = 2'b10;
    cyc(5);
    chk("latch_clear", 0, latched_o);
  endtask : t_aux
  task automatic t_ovp();
    restart(1'b1, 1'b0);
    wt(0, 1'b1, n);
    supply_overvoltage_i = 1'b1;
    cyc(4);
    chk("ovp_gate", 0, gate_o);
    cyc(4);
    chk("ovp_latched", 0, latched_o);
    supply_overvoltage_i = 1'b0;
    wt(0, 1'b1, n);
    chk("ovp_recover", 1, gate_o);
    shutdown_above_2v5_i = 1'b1;
    cyc(6);
    chk("sd_fault", 1, programmable_overvoltage_fault_o);
    chk("sd_latched", 1, latched_o);
  endtask : t_ovp
  initial
  begin
    restart(1'b0, 1'b0);
    t_low_line();
    t_high_fold();
    t_short();
    t_aux();
    t_ovp();
    end_of_test();
  end
  // Whole run needs about 4500 cycles; the limit leaves wide margin
  initial
  begin
    #(20 * 40000);
    mismatches++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

//--- verilog/qvf_cfg.svh
`ifndef QVF_CFG_SVH
`define QVF_CFG_SVH
// ----------------------------------------------------------------------------
// Timing figures, each as printed, and the cycle counts derived at 50 MHz
// ----------------------------------------------------------------------------
`define QVF_CLK_MHZ           50
`define QVF_TIMEOUT_NS        6500
`define QVF_TIMEOUT_CYC       ((`QVF_TIMEOUT_NS * `QVF_CLK_MHZ) / 1000)
`define QVF_AUX_MS            90
`define QVF_AUX_CYC           (`QVF_AUX_MS * 1000 * `QVF_CLK_MHZ)
`define QVF_LL_MS             25
`define QVF_LL_CYC            (`QVF_LL_MS * 1000 * `QVF_CLK_MHZ)
`define QVF_RECOV_S           4
`define QVF_RECOV_CYC         (`QVF_RECOV_S * 1000 * 1000 * `QVF_CLK_MHZ)
`define QVF_LIMIT_BLANK_NS    300
`define QVF_LIMIT_BLANK_CYC   ((`QVF_LIMIT_BLANK_NS * `QVF_CLK_MHZ + 999) / 1000)
`define QVF_SHORT_BLANK_NS    100
`define QVF_SHORT_BLANK_CYC   ((`QVF_SHORT_BLANK_NS * `QVF_CLK_MHZ + 999) / 1000)
// ----------------------------------------------------------------------------
// Field values
// ----------------------------------------------------------------------------
`define QVF_OVERSHOOT_CYCLES  3'h4
`define QVF_VALLEY_LOW_LINE   4'h1
`define QVF_VALLEY_HIGH_LINE  4'h2
`define QVF_REF_250MV         1'b0
`define QVF_REF_200MV         1'b1
`endif

//--- verilog/qvf_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "qvf_cfg.svh"
// Operation
// - Current reference is 250 or 200 mV by variant, lowered under foldback
// - Major fault enters latch-off or recovery and grounds comp, except UVLO
// - Comp grounded after reset and faults until restart; 80 uA boost until amplifier first sinks
// - Supply dip during failed start retries at turn-on, keeping comp level
// - Aux short timer restarts above 1 V; 90 ms flags fault, stops switching
// - Aux short: recovery variants wait 4 s, latching variants latch off
// - Each fall of valley sense below 55 mV is a valley event
// - Valley sense low for 6.5 us makes a substitute valley clock
// - Gate starts on valley 1 at low line, valley 2 at high line
// - Thermal foldback waits more valley clocks before the next gate pulse
// - Low line after 25 ms below threshold; high line at once above
// - Peak limit comparator ends the gate pulse once limit blanking has passed
// - Short blanking window much shorter than limit blanking window
// - Over 150 percent of limit in four consecutive periods is a short fault
// - Supply overvoltage stops pulses and auto-recovers on every variant
// - Shutdown pin above 2.5 V trips programmable overvoltage fault by variant
// - Latched fault clears only when supply drops below reset level
// - After recovery delay, resume once supply exceeds turn-on level
// - Gate pulse ends when current sense exceeds a quarter of control
module qvf_controller
  import qvf_pkg::*;
#(
  parameter int unsigned AUX_CYC   = `QVF_AUX_CYC,
  parameter int unsigned LL_CYC    = `QVF_LL_CYC,
  parameter int unsigned RECOV_CYC = `QVF_RECOV_CYC
)
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       variant_latching_i,
  input  wire logic       variant_low_ref_i,
  input  wire logic       valley_below_55mv_i,
  input  wire logic       valley_above_1v_i,
  input  wire logic       line_below_low_line_i,
  input  wire logic       line_above_high_line_i,
  input  wire logic       cs_above_peak_limit_i,
  input  wire logic       cs_above_150pct_i,
  input  wire logic       cs_above_setpoint_i,
  input  wire logic       supply_above_turn_on_i,
  input  wire logic       supply_below_turn_off_i,
  input  wire logic       supply_below_reset_i,
  input  wire logic       supply_overvoltage_i,
  input  wire logic       shutdown_above_2v5_i,
  input  wire logic       thermal_foldback_i,
  input  wire logic [3:0] foldback_valleys_i,
  input  wire logic       amp_sinking_i,
  output logic            gate_o,
  output logic            comp_ground_o,
  output logic            comp_boost_o,
  output logic            ref_low_o,
  output logic            ref_foldback_o,
  output logic            high_line_o,
  output logic            aux_short_fault_o,
  output logic            winding_diode_short_fault_o,
  output logic            programmable_overvoltage_fault_o,
  output logic            latched_o
);
  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw = {valley_below_55mv_i, valley_above_1v_i, line_below_low_line_i,
                line_above_high_line_i, cs_above_peak_limit_i, cs_above_150pct_i,
                cs_above_setpoint_i, supply_above_turn_on_i, supply_below_turn_off_i,
                supply_below_reset_i, supply_overvoltage_i, shutdown_above_2v5_i,
                thermal_foldback_i, amp_sinking_i, variant_latching_i, variant_low_ref_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate
  logic zlow, zhigh, llow, lhigh, ilim, i150, iset, von, voff, vrst, vovp, sdovp;
  logic tfold, sinking, latch_pin, ref_pin;
  assign {zlow, zhigh, llow, lhigh, ilim, i150, iset, von, voff, vrst, vovp, sdovp,
          tfold, sinking, latch_pin, ref_pin} = s2_q;

  // --------------------------------------------------------------------------
  // Timers
  // --------------------------------------------------------------------------
  qvf_timer_if t_zto ();
  qvf_timer_if t_aux ();
  qvf_timer_if t_ll ();
  qvf_timer_if t_rec ();
  qvf_timer_if t_lblank ();
  qvf_timer_if t_sblank ();
  qvf_timer u_zto  (.clock_i(clock_i), .rst_i(rst_i), .tmr(t_zto));
  qvf_timer u_aux  (.clock_i(clock_i), .rst_i(rst_i), .tmr(t_aux));
  qvf_timer u_ll   (.clock_i(clock_i), .rst_i(rst_i), .tmr(t_ll));
  qvf_timer u_rec  (.clock_i(clock_i), .rst_i(rst_i), .tmr(t_rec));
  qvf_timer u_lblank (.clock_i(clock_i), .rst_i(rst_i), .tmr(t_lblank));
  qvf_timer u_sblank (.clock_i(clock_i), .rst_i(rst_i), .tmr(t_sblank));

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  qvf_state_t st_q, st_d;
  logic zlow_q, zlow_d, zto_q, zto_d, hl_q, hl_d, gate_q, gate_d;
  logic [3:0] vcnt_q, vcnt_d;
  logic [2:0] ovs_q, ovs_d;
  logic hit150_q, hit150_d, boost_q, boost_d, ground_q, ground_d;
  logic auxf_q, auxf_d, wodf_q, wodf_d, ovp2f_q, ovp2f_d, latchv_q, latchv_d;
  logic rlow_q, rlow_d, rfold_q, rfold_d, primed_q, primed_d, latched_q;
  logic valley_clk, need_vall, fault_any, fault_latchable;
  logic [3:0] target;

  assign t_zto.run      = zlow && !zto_q && !gate_q && st_q == QVF_RUN;
  assign t_zto.restart  = 1'b0;
  assign t_zto.limit    = `QVF_TIMEOUT_CYC;
  assign t_aux.run      = st_q == QVF_RUN;
  assign t_aux.restart  = zhigh;
  assign t_aux.limit    = AUX_CYC;
  assign t_ll.run       = llow;
  assign t_ll.restart   = 1'b0;
  assign t_ll.limit     = LL_CYC;
  assign t_rec.run      = st_q == QVF_RECOVER;
  assign t_rec.restart  = 1'b0;
  assign t_rec.limit    = RECOV_CYC;
  assign t_lblank.run     = gate_q;
  assign t_lblank.restart = 1'b0;
  assign t_lblank.limit   = `QVF_LIMIT_BLANK_CYC;
  assign t_sblank.run     = gate_q;
  assign t_sblank.restart = 1'b0;
  assign t_sblank.limit   = `QVF_SHORT_BLANK_CYC;

  // --------------------------------------------------------------------------
  // Valley clock and fault detection
  // --------------------------------------------------------------------------
  always_comb
  begin
    zlow_d     = zlow;
    // The time-out done level lasts two cycles; only its first one counts
    valley_clk = (zlow && !zlow_q) || (t_zto.done && !zto_q);
    // Re-armed by each gate pulse, so a stuck-low sense keeps switching only while target is 1
    zto_d      = zlow && !gate_q && (zto_q || t_zto.done);
    hl_d       = hl_q;
    if (lhigh)
      hl_d = 1'b1;
    else if (t_ll.done)
      hl_d = 1'b0;
    if (tfold && foldback_valleys_i > `QVF_VALLEY_HIGH_LINE)
      target = foldback_valleys_i;
    else if (hl_q)
      target = `QVF_VALLEY_HIGH_LINE;
    else
      target = `QVF_VALLEY_LOW_LINE;
    need_vall = valley_clk && (vcnt_q + 4'h1 >= target);
    auxf_d    = auxf_q || (t_aux.done && st_q == QVF_RUN);
    hit150_d  = gate_q && (hit150_q || (t_sblank.done && i150));
    ovs_d     = ovs_q;
    wodf_d    = wodf_q;
    if (gate_q && !gate_d_pre())
    begin
      ovs_d = (hit150_d) ? ovs_q + 3'h1 : 3'h0;
      if (hit150_d && ovs_q + 3'h1 >= `QVF_OVERSHOOT_CYCLES)
        wodf_d = 1'b1;
    end
    ovp2f_d         = ovp2f_q || (sdovp && st_q == QVF_RUN);
    // Faults and the overshoot run are forgotten on each fresh start from off
    if (st_q == QVF_OFF && von)
    begin
      ovs_d   = 3'h0;
      auxf_d  = 1'b0;
      wodf_d  = 1'b0;
      ovp2f_d = 1'b0;
    end
    fault_latchable = auxf_d || wodf_d || ovp2f_d;
    fault_any       = fault_latchable || vovp;
  end

  function automatic logic gate_d_pre();
    gate_d_pre = !((ilim && t_lblank.done) || iset);
  endfunction : gate_d_pre

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_d     = st_q;
    gate_d   = 1'b0;
    vcnt_d   = vcnt_q;
    ground_d = ground_q;
    boost_d  = boost_q;
    latchv_d = latchv_q;
    primed_d = 1'b0;
    rlow_d   = rlow_q;
    rfold_d  = tfold;
    if (!primed_q)
    begin
      latchv_d = latch_pin;
      rlow_d   = ref_pin;
    end
    case (st_q)
      QVF_OFF:
      begin
        if (von)
        begin
          st_d    = QVF_RUN;
          boost_d = ground_q;
          ground_d = 1'b0;
          vcnt_d  = 4'h0;
        end
      end
      QVF_RUN:
      begin
        if (sinking)
          boost_d = 1'b0;
        if (gate_q)
          gate_d = gate_d_pre();
        else if (valley_clk)
          vcnt_d = need_vall ? 4'h0 : vcnt_q + 4'h1;
        if (need_vall && !gate_q)
          gate_d = 1'b1;
        if (fault_any)
        begin
          gate_d   = 1'b0;
          ground_d = 1'b1;
          boost_d  = 1'b0;
          if (latchv_q && fault_latchable)
            st_d = QVF_LATCHED;
          else
            st_d = QVF_RECOVER;
        end
        else if (voff)
        begin
          gate_d  = 1'b0;
          boost_d = 1'b0;
          st_d    = QVF_OFF;
        end
      end
      QVF_RECOVER:
      begin
        if (t_rec.done && von)
          st_d = QVF_OFF;
      end
      QVF_LATCHED:
      begin
        if (vrst)
          st_d = QVF_OFF;
      end
      default: st_d = QVF_OFF;
    endcase
    if (st_q != QVF_RUN && st_q != QVF_OFF)
      ground_d = 1'b1;
    // Straps lock on the first start, once the synchronisers have filled
    if (st_q == QVF_OFF && st_d == QVF_RUN)
      primed_d = 1'b1;
    else
      primed_d = primed_q;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q     <= QVF_OFF;
      zlow_q   <= 1'b0;
      zto_q    <= 1'b0;
      hl_q     <= 1'b0;
      gate_q   <= 1'b0;
      vcnt_q   <= 4'h0;
      ovs_q    <= 3'h0;
      hit150_q <= 1'b0;
      boost_q  <= 1'b0;
      ground_q <= 1'b1;
      auxf_q   <= 1'b0;
      wodf_q   <= 1'b0;
      ovp2f_q  <= 1'b0;
      latchv_q <= 1'b0;
      rlow_q   <= 1'b0;
      rfold_q  <= 1'b0;
      primed_q <= 1'b0;
      latched_q <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      zlow_q   <= zlow_d;
      zto_q    <= zto_d;
      hl_q     <= hl_d;
      gate_q   <= gate_d;
      vcnt_q   <= vcnt_d;
      ovs_q    <= ovs_d;
      hit150_q <= hit150_d;
      boost_q  <= boost_d;
      ground_q <= ground_d;
      auxf_q   <= auxf_d;
      wodf_q   <= wodf_d;
      ovp2f_q  <= ovp2f_d;
      latchv_q <= latchv_d;
      rlow_q   <= rlow_d;
      rfold_q  <= rfold_d;
      primed_q <= primed_d;
      latched_q <= st_d == QVF_LATCHED;
    end
  end

  assign gate_o                           = gate_q;
  assign comp_ground_o                    = ground_q;
  assign comp_boost_o                     = boost_q;
  assign ref_low_o                        = rlow_q;
  assign ref_foldback_o                   = rfold_q;
  assign high_line_o                      = hl_q;
  assign aux_short_fault_o                = auxf_q;
  assign winding_diode_short_fault_o      = wodf_q;
  assign programmable_overvoltage_fault_o = ovp2f_q;
  assign latched_o                        = latched_q;
endmodule : qvf_controller
`default_nettype wire

//--- verilog/qvf_pkg.sv
`default_nettype none
package qvf_pkg;
  typedef enum logic [3:0] {
    QVF_OFF     = 4'h1,
    QVF_RUN     = 4'h2,
    QVF_RECOVER = 4'h4,
    QVF_LATCHED = 4'h8
  } qvf_state_t;
  typedef logic [31:0] qvf_count_t;
endpackage : qvf_pkg
`default_nettype wire

//--- verilog/qvf_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Counts while run is high; done is a level once limit cycles have passed
module qvf_timer
  import qvf_pkg::*;
(
  input  wire logic    clock_i,
  input  wire logic    rst_i,
  qvf_timer_if.timer   tmr
);
  qvf_count_t cnt_q;
  qvf_count_t cnt_d;
  logic       done_q;
  logic       done_d;

  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = done_q;
    if (tmr.restart || !tmr.run)
    begin
      cnt_d  = 32'h0;
      done_d = 1'b0;
    end
    else if (cnt_q >= tmr.limit - 32'h1)
      done_d = 1'b1;
    else
      cnt_d = cnt_q + 32'h1;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= 32'h0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign tmr.done = done_q;
endmodule : qvf_timer
`default_nettype wire

//--- verilog/qvf_timer_if.sv
`timescale 1ns/10ps
`default_nettype none
interface qvf_timer_if;
  logic run;
  logic restart;
  logic [31:0] limit;
  logic done;
  modport owner (output run, output restart, output limit, input done);
  modport timer (input run, input restart, input limit, output done);
endinterface : qvf_timer_if
`default_nettype wire
